// >>> src/panel_indicator.sv
`timescale 1ns/10ps
`default_nettype none
`include "indicator_cfg.svh"
// Summary of operation
// R1: link runs 19200 baud, 8E1
// R2: one role at a time, master by default
// R3: master polls holding register per used line
// R4: lines configured apart from views
// R5: hidden views skipped while stepping
// R6: slave stores write-multiple data into lines
// R7: slave answers own address only
// R8: three keys, short or long press
// R9: up scrolls back or increments number
// R10: down scrolls forward or decrements digit
// R11: long up/down starts autoscroll
// R12: short set commits current edit
// R13: long set toggles menu, discards edit
// R14: slave address latched only at restart
// R15: data big endian, checksum little endian
// R16: only function codes 3 and 16
// R17: autoscroll dwell 3 to 60 s, default 5
// R18: long press fires once past threshold
// R19: 3.5 char gap frames; bad checksum dropped
// R20: master polls strictly one at a time
module panel_indicator
    import indicator_pkg::*;
#(
    parameter int BIT_CYC = `CLK_HZ / `BAUD,
    parameter int GAP_CYC = (BIT_CYC * `CHAR_BITS * `GAP_TENTHS + 9) / 10,
    parameter int LONG_CYC = `CLK_HZ / 1000 * `LONG_MS,
    parameter int DEB_CYC = `CLK_HZ / 1000 * `DEB_MS,
    parameter int RESP_CYC = `CLK_HZ / 1000 * `RESP_MS,
    parameter int SEC_CYC = `CLK_HZ
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rs485_rx,
    output logic rs485_tx,
    output logic rs485_oe,
    input wire keys_t keys,
    input wire logic mode_slave,
    input wire logic [7:0] dev_addr,
    input wire logic [5:0] scroll_sec,
    input wire logic [9:0] view_show,
    input wire logic cfg_we,
    input wire logic [5:0] cfg_idx,
    input wire line_ent_t cfg_ent,
    output logic cfg_ready,
    input wire logic [5:0] disp_idx,
    output line_ent_t disp_ent,
    input wire logic [1:0] edit_digit,
    output logic [3:0] view,
    output logic auto_scroll,
    output logic menu_mode,
    output logic editing,
    output logic [15:0] edit_value,
    output logic [15:0] menu_value,
    output logic poll_fail
);
    keys_t sp, lp;
    logic [2:0] kin, ks, kl;
    ui_t ui;
    logic [27:0] sec_cnt;
    logic [5:0] dwell, iv;
    logic dwell_done;
    logic [3:0] next_view, prev_view;
    logic [7:0] active_addr;
    logic addr_taken;
    logic [7:0] rx_d;
    logic rx_stb, rx_err, frame_end, bus_quiet, tx_busy, tx_go;
    logic [7:0] tx_d;
    logic [7:0] rx_buf [`RXBUF];
    logic [4:0] rx_cnt;
    logic [15:0] rx_crc, tx_crc, off, found, qty, wr_word;
    logic rx_bad, frm_ok, hit, is_wr, reply_ok, wr_ok, p_we;
    link_t st;
    logic [5:0] idx;
    logic [47:0] txv;
    logic [2:0] tx_len, tx_i;
    logic [27:0] wait_cnt;
    line_ent_t rd, p_wd;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
        return x;
    endfunction

    // nearest shown view in the given direction; stays put if none shown
    function automatic logic [3:0] step_view(input logic [3:0] cur, input logic fwd,
                                             input logic [9:0] shown);
        logic [3:0] v, r;
        logic got;
        v = cur;
        r = cur;
        got = 1'b0;
        for (int i = 0; i < `VIEWS; i++) begin
            if (fwd) v = (v == 4'(`VIEWS - 1)) ? 4'h0 : v + 4'h1;
            else v = (v == 4'h0) ? 4'(`VIEWS - 1) : v - 4'h1;
            if (!got && shown[v]) begin
                r = v;
                got = 1'b1;
            end
        end
        return r;
    endfunction

    rtu_uart #(.BIT_CYC(BIT_CYC), .GAP_CYC(GAP_CYC)) u_uart (
        .ref_clk(ref_clk), .rst_n(rst_n), .rx_in(rs485_rx), .tx_out(rs485_tx),
        .tx_oe(rs485_oe), .tx_go(tx_go), .tx_data(tx_d), .tx_busy(tx_busy),
        .rx_data(rx_d), .rx_stb(rx_stb), .rx_err(rx_err), .bus_quiet(bus_quiet),
        .frame_end(frame_end)
    );

    // line table lives apart from views; renderer reads it by index
    line_ram u_lines ( // R4
        .ref_clk(ref_clk), .rst_n(rst_n), .we(cfg_we & cfg_ready | p_we),
        .wa(p_we ? idx : cfg_idx), .wd(p_we ? p_wd : cfg_ent), .ra(idx), .rd(rd),
        .rb(disp_idx), .rdb(disp_ent)
    );

    // per-key press classifier
    assign kin = keys;
    genvar g;
    for (g = 0; g < 3; g++) begin : g_key
        logic [27:0] cnt;
        logic fired, s_p, l_p;
        assign ks[g] = s_p;
        assign kl[g] = l_p;
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                cnt <= 28'h0000000;
                fired <= 1'b0;
                s_p <= 1'b0;
                l_p <= 1'b0;
            end else begin
                s_p <= 1'b0;
                l_p <= 1'b0;
                if (kin[g]) begin
                    if (cnt != 28'(LONG_CYC)) cnt <= cnt + 28'h0000001;
                    if (cnt == 28'(LONG_CYC - 1)) begin
                        l_p <= 1'b1; // R18
                        fired <= 1'b1;
                    end
                end else begin
                    s_p <= !fired && cnt >= 28'(DEB_CYC); // R8
                    cnt <= 28'h0000000;
                    fired <= 1'b0;
                end
            end
        end
    end
    assign sp = ks;
    assign lp = kl;

    // mode and number entry
    assign menu_mode = (ui == UI_MENU);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ui <= UI_DISP;
            editing <= 1'b0;
            edit_value <= 16'h0000;
            menu_value <= 16'h0000;
        end else if (lp.set) begin
            ui <= menu_mode ? UI_DISP : UI_MENU; // R13
            editing <= 1'b0; // R13
        end else if (menu_mode) begin
            if (sp.set) begin
                if (editing) menu_value <= edit_value; // R12
                else edit_value <= menu_value;
                editing <= !editing;
            end else if (editing && sp.up) begin
                edit_value <= edit_value + 16'h0001; // R9
            end else if (editing && sp.down) begin
                edit_value <= edit_value - (16'h0001 << {edit_digit, 2'b00}); // R10
            end
        end
    end

    // view stepping, manual or timed
    assign next_view = step_view(view, 1'b1, view_show);
    assign prev_view = step_view(view, 1'b0, view_show);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            view <= 4'h0;
            auto_scroll <= 1'b0;
        end else if (!menu_mode) begin
            if (lp.up || lp.down) begin
                auto_scroll <= 1'b1; // R11
            end else if (sp.up) begin
                auto_scroll <= 1'b0;
                view <= prev_view; // R9 R5
            end else if (sp.down) begin
                auto_scroll <= 1'b0;
                view <= next_view; // R10 R5
            end else if ((auto_scroll && dwell_done) || !view_show[view]) begin
                view <= next_view; // R5
            end
        end
    end

    // dwell timer; zero means unset and falls back to the default
    always_comb begin
        if (scroll_sec == 6'h00) iv = `SCROLL_DEF; // R17
        else if (scroll_sec < `SCROLL_MIN) iv = `SCROLL_MIN;
        else if (scroll_sec > `SCROLL_MAX) iv = `SCROLL_MAX;
        else iv = scroll_sec;
    end
    assign dwell_done = (sec_cnt == 28'(SEC_CYC - 1)) && (dwell == iv - 6'h01);
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !auto_scroll || menu_mode || dwell_done) begin
            sec_cnt <= 28'h0000000;
            dwell <= 6'h00;
        end else if (sec_cnt == 28'(SEC_CYC - 1)) begin
            sec_cnt <= 28'h0000000;
            dwell <= dwell + 6'h01; // R17
        end else begin
            sec_cnt <= sec_cnt + 28'h0000001;
        end
    end

    // address is caught once after restart, later edits wait for the next one
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            active_addr <= 8'h00;
            addr_taken <= 1'b0;
        end else if (!addr_taken) begin
            active_addr <= dev_addr; // R14
            addr_taken <= 1'b1;
        end
    end

    // frame collection with running checksum; residue zero means intact
    always_ff @(posedge ref_clk) begin
        if (!rst_n || frame_end) begin
            rx_cnt <= 5'h00;
            rx_crc <= `CRC_INIT;
            rx_bad <= 1'b0;
        end else if (rx_stb) begin
            if (rx_cnt < 5'(`RXBUF)) rx_buf[rx_cnt[3:0]] <= rx_d;
            else rx_bad <= 1'b1;
            if (rx_cnt != 5'h1F) rx_cnt <= rx_cnt + 5'h01;
            rx_crc <= crc_step(rx_crc, rx_d);
            if (rx_err) rx_bad <= 1'b1;
        end
    end
    assign frm_ok = frame_end && !rx_bad && rx_crc == 16'h0000 && rx_cnt >= 5'h04; // R19

    // frame decode, registers sent high byte first
    assign qty = {rx_buf[4], rx_buf[5]}; // R15
    assign off = rd.reg_no - {rx_buf[2], rx_buf[3]};
    assign hit = rd.used && off < qty;
    assign wr_word = {rx_buf[4'h7 + {1'b0, off[1:0], 1'b0}], rx_buf[4'h8 + {1'b0, off[1:0], 1'b0}]};
    assign wr_ok = qty != 16'h0000 && qty <= 16'(`MAX_WORDS) && rx_buf[6] == {qty[6:0], 1'b0}
                   && rx_cnt == 5'(9) + {qty[3:0], 1'b0};
    assign reply_ok = rx_buf[0] == rd.slave && rx_buf[1] == `FC_READ && rx_buf[2] == 8'h02
                      && rx_cnt == 5'h07;
    assign p_we = (st == S_WAIT && frm_ok && reply_ok) || (st == S_SCAN_RD && hit && is_wr);
    assign p_wd = '{used: rd.used, slave: rd.slave, reg_no: rd.reg_no,
                    value: (st == S_WAIT) ? {rx_buf[3], rx_buf[4]} : wr_word}; // R3 R6
    assign cfg_ready = !p_we;

    // link sequencer for both roles
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st <= S_IDLE;
            idx <= 6'h00;
            txv <= 48'h000000000000;
            tx_len <= 3'h0;
            tx_i <= 3'h0;
            tx_crc <= `CRC_INIT;
            tx_go <= 1'b0;
            tx_d <= 8'h00;
            wait_cnt <= 28'h0000000;
            found <= 16'h0000;
            is_wr <= 1'b0;
            poll_fail <= 1'b0;
        end else begin
            tx_go <= 1'b0;
            poll_fail <= 1'b0;
            case (st)
                S_IDLE: begin
                    tx_i <= 3'h0;
                    tx_crc <= `CRC_INIT;
                    if (mode_slave) begin // R2
                        if (frm_ok && rx_buf[0] == active_addr) begin // R7
                            idx <= 6'h00;
                            found <= 16'h0000;
                            is_wr <= rx_buf[1] == `FC_WRITE;
                            if ((rx_buf[1] == `FC_WRITE && wr_ok) ||
                                (rx_buf[1] == `FC_READ && qty == 16'h0001 && rx_cnt == 5'h08)) begin
                                st <= S_SCAN; // R16
                            end else begin
                                txv <= {active_addr, rx_buf[1] | 8'h80,
                                        (rx_buf[1] == `FC_WRITE || rx_buf[1] == `FC_READ)
                                        ? `EXC_VAL : `EXC_FN, 24'h000000}; // R16
                                tx_len <= 3'h3;
                                st <= S_SEND;
                            end
                        end
                    end else if (bus_quiet) begin
                        st <= S_READ; // R20
                    end
                end
                S_READ: begin
                    if (rd.used) begin
                        txv <= {rd.slave, `FC_READ, rd.reg_no, 16'h0001}; // R3
                        tx_len <= 3'h6;
                        st <= S_SEND;
                    end else begin
                        idx <= (idx == 6'(`LINES - 1)) ? 6'h00 : idx + 6'h01;
                        st <= S_IDLE;
                    end
                end
                S_SEND: begin
                    if (!tx_busy && !tx_go) begin
                        tx_go <= 1'b1;
                        tx_i <= tx_i + 3'h1;
                        if (tx_i < tx_len) begin
                            tx_d <= txv[47:40];
                            txv <= txv << 8;
                            tx_crc <= crc_step(tx_crc, txv[47:40]);
                        end else if (tx_i == tx_len) begin
                            tx_d <= tx_crc[7:0]; // R15
                        end else begin
                            tx_d <= tx_crc[15:8];
                            wait_cnt <= 28'h0000000;
                            st <= mode_slave ? S_IDLE : S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    wait_cnt <= wait_cnt + 28'h0000001;
                    if ((frm_ok && reply_ok) || wait_cnt == 28'(RESP_CYC - 1)) begin
                        poll_fail <= !(frm_ok && reply_ok); // R20
                        idx <= (idx == 6'(`LINES - 1)) ? 6'h00 : idx + 6'h01;
                        st <= S_IDLE;
                    end
                end
                S_SCAN: st <= S_SCAN_RD;
                S_SCAN_RD: begin
                    if (hit && !is_wr) found <= rd.value;
                    if (idx == 6'(`LINES - 1)) begin
                        idx <= 6'h00;
                        txv <= is_wr ? {active_addr, `FC_WRITE, rx_buf[2], rx_buf[3],
                                        rx_buf[4], rx_buf[5]}
                                     : {active_addr, `FC_READ, 8'h02,
                                        (hit ? rd.value : found), 8'h00}; // R6
                        tx_len <= is_wr ? 3'h6 : 3'h5;
                        st <= S_SEND;
                    end else begin
                        idx <= idx + 6'h01;
                        st <= S_SCAN;
                    end
                end
                default: st <= S_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_edit_set;
        menu_mode && editing && sp.set && !lp.set;
    endsequence
    property p_commit;
        s_edit_set |=> !editing && menu_value == $past(edit_value);
    endproperty
    a_commit: assert property (p_commit) else $error("edit not committed"); // R12
    property p_menu_toggle;
        lp.set && editing |=> !editing && menu_mode != $past(menu_mode);
    endproperty
    a_menu_toggle: assert property (p_menu_toggle) else $error("long set mishandled"); // R13
    property p_auto;
        !menu_mode && (lp.up || lp.down) |=> auto_scroll;
    endproperty
    a_auto: assert property (p_auto) else $error("autoscroll not entered"); // R11
    property p_shown;
        view != $past(view) |-> view_show[view];
    endproperty
    a_shown: assert property (p_shown) else $error("hidden view reached"); // R5
    property p_scroll_up;
        !menu_mode && sp.up && !lp.up && !lp.down |=> view == $past(prev_view);
    endproperty
    a_scroll_up: assert property (p_scroll_up) else $error("up did not step back"); // R9
    property p_addr_hold;
        addr_taken && $past(addr_taken) |-> $stable(active_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("slave address moved"); // R14
    property p_one_poll;
        st == S_WAIT |=> !tx_go && (st == S_WAIT || st == S_IDLE);
    endproperty
    a_one_poll: assert property (p_one_poll) else $error("overlapping poll"); // R20
    property p_foreign;
        st == S_IDLE && mode_slave && frm_ok && rx_buf[0] != active_addr |=> st == S_IDLE;
    endproperty
    a_foreign: assert property (p_foreign) else $error("answered foreign address"); // R7
    property p_long_once;
        lp.set |-> g_key[0].fired && !sp.set ##1 !lp.set;
    endproperty
    a_long_once: assert property (p_long_once) else $error("long press misfired"); // R18
endmodule
`default_nettype wire

// >>> src/indicator_cfg.svh
`ifndef INDICATOR_CFG_SVH
`define INDICATOR_CFG_SVH
`define CLK_HZ 250000000
`define BAUD 19200
`define CHAR_BITS 11
`define GAP_TENTHS 35
`define LINES 40
`define VIEWS 10
`define FC_READ 8'h03
`define FC_WRITE 8'h10
`define EXC_FN 8'h01
`define EXC_VAL 8'h03
`define MAX_WORDS 4
`define RXBUF 16
`define LONG_MS 1000
`define DEB_MS 20
`define RESP_MS 100
`define SCROLL_MIN 6'h03
`define SCROLL_MAX 6'h3C
`define SCROLL_DEF 6'h05
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`endif

// >>> src/indicator_pkg.sv
package indicator_pkg;
    typedef struct packed {
        logic up;
        logic down;
        logic set;
    } keys_t;
    typedef struct packed {
        logic used;
        logic [7:0] slave;
        logic [15:0] reg_no;
        logic [15:0] value;
    } line_ent_t;
    typedef enum logic {UI_DISP, UI_MENU} ui_t;
    typedef enum logic [2:0] {S_IDLE, S_READ, S_SEND, S_WAIT, S_SCAN, S_SCAN_RD} link_t;
endpackage

// >>> src/line_ram.sv
`timescale 1ns/10ps
`default_nettype none
`include "indicator_cfg.svh"
module line_ram
    import indicator_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [5:0] wa,
    input wire line_ent_t wd,
    input wire logic [5:0] ra,
    output var line_ent_t rd,
    input wire logic [5:0] rb,
    output var line_ent_t rdb
);
    line_ent_t mem [`LINES];

    // one write, two registered reads; out of range reads as empty
    always_ff @(posedge ref_clk) begin
        if (we && wa < 6'(`LINES)) mem[wa] <= wd;
        if (!rst_n || ra >= 6'(`LINES)) rd <= '0;
        else rd <= mem[ra];
        if (!rst_n || rb >= 6'(`LINES)) rdb <= '0;
        else rdb <= mem[rb];
    end
endmodule
`default_nettype wire

// >>> src/rtu_uart.sv
`timescale 1ns/10ps
`default_nettype none
module rtu_uart #(
    parameter int BIT_CYC = 13020,
    parameter int GAP_CYC = 501270
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rx_in,
    output logic tx_out,
    output logic tx_oe,
    input wire logic tx_go,
    input wire logic [7:0] tx_data,
    output logic tx_busy,
    output logic [7:0] rx_data,
    output logic rx_stb,
    output logic rx_err,
    output logic bus_quiet,
    output logic frame_end
);
    logic [10:0] tsh;
    logic [3:0] tbit;
    logic [15:0] tcyc;
    logic [10:0] rsh;
    logic [10:0] rnext;
    logic [3:0] rbit;
    logic [15:0] rcyc;
    logic rbusy;
    logic [22:0] idle;
    logic armed;

    assign tx_out = tsh[0];
    assign tx_oe = tx_busy;
    assign rnext = {rx_in, rsh[10:1]};

    // transmit: start, 8 data lsb first, even parity, one stop
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tsh <= 11'h7FF;
            tbit <= 4'h0;
            tcyc <= 16'h0000;
            tx_busy <= 1'b0;
        end else if (!tx_busy) begin
            if (tx_go) begin
                tsh <= {1'b1, ^tx_data, tx_data, 1'b0};
                tx_busy <= 1'b1;
                tbit <= 4'h0;
                tcyc <= 16'h0000;
            end
        end else if (tcyc == 16'(BIT_CYC - 1)) begin
            tcyc <= 16'h0000;
            tsh <= {1'b1, tsh[10:1]};
            if (tbit == 4'hA) tx_busy <= 1'b0;
            else tbit <= tbit + 4'h1;
        end else begin
            tcyc <= tcyc + 16'h0001;
        end
    end

    // receive; own echo is ignored since the line is half duplex
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rsh <= 11'h000;
            rbit <= 4'h0;
            rcyc <= 16'h0000;
            rbusy <= 1'b0;
            rx_data <= 8'h00;
            rx_stb <= 1'b0;
            rx_err <= 1'b0;
        end else begin
            rx_stb <= 1'b0;
            if (!rbusy) begin
                if (!rx_in && !tx_busy) begin
                    rbusy <= 1'b1;
                    rbit <= 4'h0;
                    rcyc <= 16'(BIT_CYC / 2);
                end
            end else if (rcyc == 16'(BIT_CYC - 1)) begin
                rcyc <= 16'h0000;
                rsh <= rnext;
                rbit <= rbit + 4'h1;
                if (rbit == 4'hA) begin
                    rbusy <= 1'b0;
                    rx_data <= rnext[8:1];
                    rx_stb <= 1'b1;
                    rx_err <= rnext[0] | ~rnext[10] | (^rnext[9:1]); // R1
                end
            end else begin
                rcyc <= rcyc + 16'h0001;
            end
        end
    end

    // 3.5 character silence closes a frame and frees the bus
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            idle <= 23'h000000;
            armed <= 1'b0;
            bus_quiet <= 1'b0;
            frame_end <= 1'b0;
        end else begin
            frame_end <= 1'b0;
            if (rbusy || tx_busy || !rx_in) begin
                idle <= 23'h000000;
                bus_quiet <= 1'b0;
                if (rbusy) armed <= 1'b1;
            end else if (idle == 23'(GAP_CYC - 1)) begin
                bus_quiet <= 1'b1;
                frame_end <= armed; // R19
                armed <= 1'b0;
                idle <= idle + 23'h000001;
            end else if (!bus_quiet) begin
                idle <= idle + 23'h000001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> test/rtu_listener.sv
`timescale 1ns/10ps
`default_nettype none
module rtu_listener #(
    parameter int BIT_CYC = 16
) (
    input wire logic ref_clk,
    input wire logic tx,
    output logic rx
);
    logic [7:0] got [0:31];
    int n = 0;
    int bad_par = 0;
    logic drv = 1'b1;
    // biased bus stays high: polls go unanswered, frames go out on request
    assign rx = drv;
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        return c;
    endfunction
    // checksum over collected bytes a up to b-1
    function automatic logic [15:0] crc_got(input int a, input int b);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = a; i < b; i++) c = crc(c, got[i]);
        return c;
    endfunction
    // k bytes from the top of v, then crc low byte first, 8E1
    task automatic send(input logic [79:0] v, input int k);
        logic [15:0] c;
        logic [7:0] d;
        c = 16'hFFFF;
        repeat (2 * BIT_CYC) @(negedge ref_clk);
        for (int j = 0; j < k + 2; j++) begin
            d = (j < k) ? v[79:72] : (j == k) ? c[7:0] : c[15:8];
            if (j < k) c = crc(c, d);
            v = v << 8;
            for (int i = 0; i < 11; i++) begin
                drv = (i == 0) ? 1'b0 : (i > 8) ? ((i == 9) ? ^d : 1'b1) : d[i - 1];
                repeat (BIT_CYC) @(negedge ref_clk);
            end
        end
    endtask
    // mid-bit sampling, lsb first, even parity
    always begin : grab
        logic [8:0] b;
        @(negedge tx);
        repeat (BIT_CYC + BIT_CYC / 2) @(posedge ref_clk);
        for (int i = 0; i < 9; i++) begin
            b[i] = tx;
            repeat (BIT_CYC) @(posedge ref_clk);
        end
        if (n < 32) got[n] = b[7:0];
        if (^b !== 1'b0) bad_par++;
        n++;
    end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import indicator_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rs485_rx, rs485_tx, rs485_oe, cfg_we, cfg_ready, auto_scroll, menu_mode;
    logic editing, poll_fail;
    keys_t keys;
    logic [5:0] cfg_idx, disp_idx;
    logic [1:0] edit_digit;
    logic [3:0] view;
    logic [15:0] edit_value, menu_value;
    line_ent_t cfg_ent, disp_ent;
    logic mode_slave = 1'b0;
    logic [7:0] dev_addr = 8'h05;
    logic [5:0] scroll_sec = 6'h03;
    logic [9:0] view_show = 10'h3FD;
    int mismatches = 0;
    int n_checks = 0;
    always #2 ref_clk = ~ref_clk;
    panel_indicator #(.BIT_CYC(16), .GAP_CYC(62), .LONG_CYC(200), .DEB_CYC(5),
        .RESP_CYC(3000), .SEC_CYC(100)) panel_indicator_i (
        .ref_clk, .rst_n, .rs485_rx, .rs485_tx, .rs485_oe, .keys, .mode_slave,
        .dev_addr, .scroll_sec, .view_show, .cfg_we, .cfg_idx, .cfg_ent, .cfg_ready,
        .disp_idx, .disp_ent, .edit_digit, .view, .auto_scroll, .menu_mode,
        .editing, .edit_value, .menu_value, .poll_fail);
    rtu_listener #(.BIT_CYC(16)) lis (.ref_clk, .tx(rs485_tx), .rx(rs485_rx));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // bounded wait for the listener to collect k bytes
    task automatic wait_bytes(input int k);
        for (int t = 0; t < 20000 && lis.n < k; t++) @(negedge ref_clk);
        if (lis.n < k) begin
            mismatches++;
            complete_run();
        end
    endtask
    // hold a key pattern n cycles; long enough gap after release for the pulse
    task automatic press(input keys_t k, input int n);
        keys = k;
        repeat (n) @(negedge ref_clk);
        keys = '0;
        repeat (6) @(negedge ref_clk);
    endtask
    initial begin
        keys = '0;
        cfg_we = 1'b0;
        cfg_idx = 6'h00;
        cfg_ent = '0;
        disp_idx = 6'h00;
        edit_digit = 2'h0;
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        // table is not cleared by reset: fill all entries, only line 0 used
        for (int i = 0; i < 40; i++) begin
            cfg_we = 1'b1;
            cfg_idx = 6'(i);
            cfg_ent = (i == 0) ? '{1'b1, 8'h11, 16'h1234, 16'h0000} : '0;
            @(negedge ref_clk);
        end
        cfg_we = 1'b0;
        @(negedge ref_clk);
        check(disp_ent.reg_no, 16'h1234);
        check(cfg_ready, 1'b1);
        disp_idx = 6'h01;
        @(negedge ref_clk);
        check(disp_ent.used, 1'b0);
        disp_idx = 6'h00;
        wait_bytes(8);
        check(lis.got[0], 8'h11);
        check(lis.got[1], 8'h03);
        check(lis.got[2], 8'h12);
        check(lis.got[3], 8'h34);
        check(lis.got[5], 8'h01);
        check(rs485_oe, 1'b1);
        check({lis.got[7], lis.got[6]}, lis.crc_got(0, 6));
        check(16'(lis.bad_par), 16'h0000);
        for (int t = 0; t < 8000 && poll_fail !== 1'b1; t++) @(negedge ref_clk);
        check(poll_fail, 1'b1);
        check(rs485_oe, 1'b0);
        check(16'(lis.n), 16'h0008);
        wait_bytes(9);
        check(lis.got[8], 8'h11);
        // view 1 hidden, so stepping skips it
        press(3'b010, 10);
        check(view, 4'h2);
        press(3'b100, 10);
        check(view, 4'h0);
        press(3'b010, 220);
        check(auto_scroll, 1'b1);
        check(view, 4'h0);
        repeat (310) @(negedge ref_clk);
        check(view, 4'h2);
        press(3'b100, 10);
        check(auto_scroll, 1'b0);
        press(3'b001, 220);
        check(menu_mode, 1'b1);
        press(3'b001, 10);
        check(editing, 1'b1);
        press(3'b100, 10);
        check(edit_value, 16'h0001);
        edit_digit = 2'h1;
        press(3'b010, 10);
        check(edit_value, 16'hFFF1);
        press(3'b001, 10);
        check(menu_value, 16'hFFF1);
        check(editing, 1'b0);
        // edit again, then abandon with a long set
        press(3'b001, 10);
        press(3'b100, 10);
        press(3'b001, 220);
        check(menu_mode, 1'b0);
        check(editing, 1'b0);
        check(menu_value, 16'hFFF1);
        // second poll times out too; then switch to the slave role
        for (int t = 0; t < 8000 && poll_fail !== 1'b1; t++) @(negedge ref_clk);
        check(poll_fail, 1'b1);
        mode_slave = 1'b1;
        // new address must wait for a restart, so 0x09 is still foreign
        dev_addr = 8'h09;
        lis.send({8'h09, 8'h06, 64'h0}, 2);
        repeat (300) @(negedge ref_clk);
        check(16'(lis.n), 16'h0010);
        lis.send({8'h05, 8'h06, 64'h0}, 2);
        wait_bytes(21);
        check(lis.got[16], 8'h05);
        check(lis.got[17], 8'h86);
        check(lis.got[18], 8'h01);
        check({lis.got[20], lis.got[19]}, lis.crc_got(16, 19));
        // write one register that line 0 listens to
        lis.send({72'h05_10_12_34_00_01_02_AB_CD, 8'h00}, 9);
        wait_bytes(29);
        check(lis.got[22], 8'h10);
        check(lis.got[26], 8'h01);
        check(disp_ent.value, 16'hABCD);
        complete_run();
    end
endmodule
`default_nettype wire
